//--- verilog/clk_startup_pkg.sv
/*
 Constants, encodings and carrier types for the clock source and start-up controller.
 Assumes one 50 MHz system clock (mclk) and a synchronous active-low reset (rstn).
*/
// Operation
// - Two-bit source field picks external, reserved, calibrated internal or low-frequency oscillator.
// - A fuse bit at 1 means unprogrammed, at 0 means programmed.
// - Default fuses: calibrated oscillator, longest start-up, divide-by-eight programmed.
// - Internal reset stays asserted for a time-out after other resets release.
// - Time-out counts watchdog oscillator cycles chosen by start-up and reset-pin-disable fields.
// - Time-out is 0, 4096 or 8192 watchdog cycles; code 11 and source 01 reserved.
// - Ripple count of selected oscillator cycles keeps reset until stable, then run.
// - Reset start-up uses time-out plus oscillator time; power-down wake uses oscillator time only.
// - Wake from power-down is 6 cycles; reset adds 14 cycles plus time-out.
// - Programmed reset-pin-disable fuse stretches start-up code 00 to the 4096 time-out.
// - During reset the factory trim value is loaded into the trim register.
// - Software may overwrite the trim register while running; oscillator follows it.
// - Watchdog oscillator keeps clocking the watchdog and time-out whatever the source.
// - Programmed divide-by-eight fuse divides the oscillator by 8 for the system clock.
// - Clocks to unused modules are gated by sleep mode; core clock stop halts core.
// - Asynchronous interrupt and start-condition detection stay enabled in every sleep mode.
// - Converter clock is its own domain, running while core and peripheral clocks stop.
// - Fast two-wire clock is the undivided source; flash clock follows the core clock.
// - Low-frequency source uses the same 6 and 14 cycle start-up delays.
package clk_startup_pkg;

   // =====================================================================
   // Fuse field encodings
   localparam logic [1:0] SRC_EXT    = 2'h0;
   localparam logic [1:0] SRC_RSVD   = 2'h1;
   localparam logic [1:0] SRC_RC     = 2'h2;
   localparam logic [1:0] SRC_LF     = 2'h3;
   localparam logic [1:0] SUT_NONE   = 2'h0;
   localparam logic [1:0] SUT_SHORT  = 2'h1;
   localparam logic [1:0] SUT_LONG   = 2'h2;
   localparam logic [1:0] SUT_RSVD   = 2'h3;
   localparam logic       FUSE_PROG  = 1'h0;
   localparam logic       FUSE_UNPRG = 1'h1;

   // =====================================================================
   // Sleep modes
   localparam logic [1:0] SLP_IDLE   = 2'h0;
   localparam logic [1:0] SLP_CONV   = 2'h1;
   localparam logic [1:0] SLP_PDOWN  = 2'h2;

   // =====================================================================
   // Timing counts
   localparam int unsigned TOUT_SHORT_WDT = 4096;
   localparam int unsigned TOUT_LONG_WDT  = 8192;
   localparam int          CNT_W          = 14;
   localparam logic [13:0] OSC_RESET_CYC  = 14'h000e;
   localparam logic [13:0] OSC_WAKE_CYC   = 14'h0006;
   localparam logic [2:0]  DIV8_LAST      = 3'h7;
   localparam logic [7:0]  TRIM_RST       = 8'h00;

   // =====================================================================
   // Synchroniser bit positions
   localparam int IN_WDT  = 0;
   localparam int IN_EXT  = 1;
   localparam int IN_RC   = 2;
   localparam int IN_LF   = 3;
   localparam int IN_RSTN = 4;
   localparam int IN_WAKE = 5;
   localparam int IN_FUSE = 6;
   localparam int SYNC_W  = 12;

   typedef struct packed {
      logic [1:0] src;
      logic [1:0] startup_time_select;
      logic       div8_n;
      logic       rstdis_n;
   } fuse_cfg_t;

   localparam fuse_cfg_t CFG_DEFAULT = '{src: SRC_RC, startup_time_select: SUT_LONG,
                                         div8_n: FUSE_PROG, rstdis_n: FUSE_UNPRG};

   typedef struct packed {
      logic core;
      logic periph;
      logic flash;
      logic conv;
   } clk_gate_t;

   typedef enum logic [2:0] {
      ST_HOLD, ST_TOUT, ST_OSC, ST_RUN, ST_SLEEP, ST_PDOWN, ST_WAKE
   } seq_st_t;

endpackage

//--- verilog/pin_sync.sv
/*
 Two-flop synchroniser bank with rising-edge detect per bit.
 Assumes sampled pins toggle well below half the mclk rate.
*/
`timescale 1ns/100ps
module pin_sync
   import clk_startup_pkg::*;
#(
   parameter int W = 1
)
(
   input  wire logic         mclk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] lvl,
   output logic      [W-1:0] rise
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } sync_t;

   sync_t cur_r;
   sync_t cur_nxt;

   // =====================================================================
   // First stage feeds only the second
   always_comb
   begin
      cur_nxt    = cur_r;
      cur_nxt.s1 = pin;
      cur_nxt.s2 = cur_r.s1;
      cur_nxt.s3 = cur_r.s2;
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         cur_r <= '0;
      else
         cur_r <= cur_nxt;
   end

   assign lvl  = cur_r.s2;
   assign rise = cur_r.s2 & ~cur_r.s3;

endmodule

//--- verilog/tick_divider.sv
/*
 Divide-by-eight pulse divider for the system clock tick.
 Assumes tick_in is a one-cycle pulse on mclk.
*/
`timescale 1ns/100ps
module tick_divider
   import clk_startup_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic clr,
   input  wire logic div_en,
   input  wire logic tick_in,
   output logic      tick_out
);

   typedef struct packed {
      logic [2:0] cnt;
   } div_t;

   div_t cur_r;
   div_t cur_nxt;

   // =====================================================================
   // Phase counter
   always_comb
   begin
      cur_nxt = cur_r;
      if (clr)
         cur_nxt.cnt = 3'h0;
      else if (tick_in)
         cur_nxt.cnt = 3'(cur_r.cnt + 3'h1);
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         cur_r <= '0;
      else
         cur_r <= cur_nxt;
   end

   assign tick_out = tick_in & (!div_en | (cur_r.cnt == DIV8_LAST));

endmodule

//--- verilog/clk_startup_ctrl.sv
/*
 Clock source selection, start-up reset sequencer, trim load and clock gating.
 Assumes oscillators, the other-reset line, wake line and fuses arrive as
 asynchronous pins; factory_trim and the trim write port are on mclk.
*/
`timescale 1ns/100ps
module clk_startup_ctrl
   import clk_startup_pkg::*;
#(
   parameter int unsigned TOUT_SHORT = TOUT_SHORT_WDT,
   parameter int unsigned TOUT_LONG  = TOUT_LONG_WDT
)
(
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       wdt_osc_pin,
   input  wire logic       ext_clk_pin,
   input  wire logic       rc_osc_pin,
   input  wire logic       lf_osc_pin,
   input  wire logic       other_reset_n_pin,
   input  wire logic       wake_pin,
   input  wire fuse_cfg_t  fuse_pins,
   input  wire logic [7:0] factory_trim,
   input  wire logic       trim_wr,
   input  wire logic [7:0] trim_wdata,
   input  wire logic       sleep_req,
   input  wire logic [1:0] sleep_mode,
   output logic            core_reset,
   output logic            sys_clk_tick,
   output logic            fast_two_wire_tick,
   output clk_gate_t       clk_gate,
   output logic [7:0]      oscillator_trim_register,
   output logic            wdt_osc_enable,
   output logic            async_detect_enable,
   output fuse_cfg_t       active_cfg
);

   typedef struct packed {
      seq_st_t          st;
      logic [CNT_W-1:0] cnt;
      fuse_cfg_t        cfg;
      logic [1:0]       smode;
      logic [7:0]       trim;
      logic             core_reset;
      logic             sys_tick;
      logic             fast_tick;
      clk_gate_t        gate;
      logic             wdt_en;
      logic             async_en;
   } ctrl_t;

   localparam ctrl_t CTRL_RST = '{st: ST_HOLD, cnt: '0, cfg: CFG_DEFAULT,
                                  smode: SLP_IDLE, trim: TRIM_RST, core_reset: 1'b1,
                                  sys_tick: 1'b0, fast_tick: 1'b0, gate: '0,
                                  wdt_en: 1'b0, async_en: 1'b0};

   ctrl_t            cur_r;
   ctrl_t            cur_nxt;
   logic [SYNC_W-1:0] sync_lvl;
   logic [SYNC_W-1:0] sync_rise;
   logic             src_tick;
   logic             div_tick;
   logic             div_clr;
   fuse_cfg_t        fuse_lvl;

   // =====================================================================
   // Input synchronisers
   pin_sync #(
      .W (SYNC_W)
   ) u_sync (
      .mclk (mclk),
      .rstn (rstn),
      .pin  ({fuse_pins, wake_pin, other_reset_n_pin,
              lf_osc_pin, rc_osc_pin, ext_clk_pin, wdt_osc_pin}),
      .lvl  (sync_lvl),
      .rise (sync_rise)
   );

   assign fuse_lvl = fuse_cfg_t'(sync_lvl[SYNC_W-1:IN_FUSE]);

   // =====================================================================
   // Decoders
   // Reserved source falls back to the calibrated oscillator so a bad fuse still boots
   function automatic fuse_cfg_t norm_cfg(input fuse_cfg_t f);
      fuse_cfg_t r;
      r = f;
      if (f.src == SRC_RSVD)
         r.src = SRC_RC;
      if (f.startup_time_select == SUT_RSVD)
         r.startup_time_select = SUT_LONG;
      return r;
   endfunction

   // Watchdog cycle count of the reset time-out
   function automatic logic [CNT_W-1:0] tout_cycles(input fuse_cfg_t f);
      fuse_cfg_t n;
      logic [CNT_W-1:0] c;
      n = norm_cfg(f);
      case (n.startup_time_select)
         SUT_NONE:  c = (n.rstdis_n == FUSE_PROG) ? CNT_W'(TOUT_SHORT) : '0;
         SUT_SHORT: c = CNT_W'(TOUT_SHORT);
         default:   c = CNT_W'(TOUT_LONG);
      endcase
      return c;
   endfunction

   function automatic logic sel_tick(input logic [1:0] src, input logic [SYNC_W-1:0] r);
      logic t;
      case (src)
         SRC_EXT: t = r[IN_EXT];
         SRC_LF:  t = r[IN_LF];
         default: t = r[IN_RC];
      endcase
      return t;
   endfunction

   assign src_tick = sel_tick(cur_r.cfg.src, sync_rise);
   assign div_clr  = (cur_r.st == ST_HOLD);

   // =====================================================================
   // System clock divider
   tick_divider u_div (
      .mclk     (mclk),
      .rstn     (rstn),
      .clr      (div_clr),
      .div_en   (cur_r.cfg.div8_n == FUSE_PROG),
      .tick_in  (src_tick),
      .tick_out (div_tick)
   );

   // =====================================================================
   // Start-up sequencer
   always_comb
   begin
      cur_nxt = cur_r;
      case (cur_r.st)
         ST_HOLD:
         begin
            // Fuses follow the pins only here, then stay frozen
            cur_nxt.cfg  = norm_cfg(fuse_lvl);
            cur_nxt.trim = factory_trim;
            cur_nxt.cnt  = '0;
            if (sync_lvl[IN_RSTN])
               cur_nxt.st = (tout_cycles(fuse_lvl) == '0) ? ST_OSC : ST_TOUT;
         end
         ST_TOUT:
         begin
            // Timed on the watchdog oscillator, not the chip source
            if (sync_rise[IN_WDT])
            begin
               cur_nxt.cnt = CNT_W'(cur_r.cnt + 1'b1);
               if (cur_nxt.cnt == tout_cycles(cur_r.cfg))
               begin
                  cur_nxt.st  = ST_OSC;
                  cur_nxt.cnt = '0;
               end
            end
         end
         ST_OSC:
         begin
            if (src_tick)
            begin
               cur_nxt.cnt = CNT_W'(cur_r.cnt + 1'b1);
               if (cur_nxt.cnt == OSC_RESET_CYC)
                  cur_nxt.st = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (trim_wr)
               cur_nxt.trim = trim_wdata;
            if (sleep_req)
            begin
               cur_nxt.smode = sleep_mode;
               cur_nxt.st    = (sleep_mode[1]) ? ST_PDOWN : ST_SLEEP;
            end
         end
         ST_SLEEP:
         begin
            if (sync_lvl[IN_WAKE])
               cur_nxt.st = ST_RUN;
         end
         ST_PDOWN:
         begin
            cur_nxt.cnt = '0;
            if (sync_lvl[IN_WAKE])
               cur_nxt.st = ST_WAKE;
         end
         ST_WAKE:
         begin
            if (src_tick)
            begin
               cur_nxt.cnt = CNT_W'(cur_r.cnt + 1'b1);
               if (cur_nxt.cnt == OSC_WAKE_CYC)
                  cur_nxt.st = ST_RUN;
            end
         end
         default:
            cur_nxt.st = ST_HOLD;
      endcase
      if (!sync_lvl[IN_RSTN])
         cur_nxt.st = ST_HOLD;

      // Registered outputs; reset and gates from the next state, ticks gated on the current state
      cur_nxt.core_reset  = (cur_nxt.st == ST_HOLD) || (cur_nxt.st == ST_TOUT)
                            || (cur_nxt.st == ST_OSC);
      cur_nxt.gate.core   = (cur_nxt.st == ST_RUN);
      cur_nxt.gate.flash  = (cur_nxt.st == ST_RUN);
      cur_nxt.gate.periph = (cur_nxt.st == ST_RUN)
                            || ((cur_nxt.st == ST_SLEEP) && (cur_nxt.smode == SLP_IDLE));
      // Converter keeps its own gate through the noise-reduction sleep
      cur_nxt.gate.conv   = (cur_nxt.st == ST_RUN) || (cur_nxt.st == ST_SLEEP);
      cur_nxt.sys_tick    = div_tick && (cur_r.st != ST_PDOWN);
      cur_nxt.fast_tick   = src_tick && (cur_r.st != ST_PDOWN);
      cur_nxt.wdt_en      = 1'b1;
      cur_nxt.async_en    = 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         cur_r <= CTRL_RST;
      else
         cur_r <= cur_nxt;
   end

   assign core_reset               = cur_r.core_reset;
   assign sys_clk_tick             = cur_r.sys_tick;
   assign fast_two_wire_tick       = cur_r.fast_tick;
   assign clk_gate                 = cur_r.gate;
   assign oscillator_trim_register = cur_r.trim;
   assign wdt_osc_enable           = cur_r.wdt_en;
   assign async_detect_enable      = cur_r.async_en;
   assign active_cfg               = cur_r.cfg;

   // =====================================================================
   // Checks
   property p_hold_resets;
      @(posedge mclk) disable iff (!rstn)
      !sync_lvl[IN_RSTN] |=> core_reset && (cur_r.st == ST_HOLD);
   endproperty
   a_hold_resets: assert property (p_hold_resets) else $error("reset not held");

   property p_tout_bound;
      @(posedge mclk) disable iff (!rstn)
      (cur_r.st == ST_TOUT) |-> (cur_r.cnt < tout_cycles(cur_r.cfg));
   endproperty
   a_tout_bound: assert property (p_tout_bound) else $error("timeout overrun");

   property p_release;
      @(posedge mclk) disable iff (!rstn)
      $fell(core_reset) |-> ($past(cur_r.st) == ST_OSC)
                            && ($past(cur_r.cnt) == OSC_RESET_CYC - 14'h1);
   endproperty
   a_release: assert property (p_release) else $error("early release");

   property p_wake_no_reset;
      @(posedge mclk) disable iff (!rstn)
      (cur_r.st == ST_PDOWN) && sync_lvl[IN_WAKE] && sync_lvl[IN_RSTN]
      |=> (cur_r.st == ST_WAKE) && !core_reset;
   endproperty
   a_wake_no_reset: assert property (p_wake_no_reset) else $error("wake used timeout");

   property p_trim_load;
      @(posedge mclk) disable iff (!rstn)
      (cur_r.st == ST_HOLD) |=> (oscillator_trim_register == $past(factory_trim));
   endproperty
   a_trim_load: assert property (p_trim_load) else $error("trim not loaded");

   property p_trim_write;
      @(posedge mclk) disable iff (!rstn)
      (cur_r.st == ST_RUN) && trim_wr |=> (oscillator_trim_register == $past(trim_wdata));
   endproperty
   a_trim_write: assert property (p_trim_write) else $error("trim write lost");

   property p_cfg_frozen;
      @(posedge mclk) disable iff (!rstn)
      (cur_r.st != ST_HOLD) |=> $stable(active_cfg);
   endproperty
   a_cfg_frozen: assert property (p_cfg_frozen) else $error("fuses changed");

   property p_no_rsvd_src;
      @(posedge mclk) disable iff (!rstn)
      (active_cfg.src != SRC_RSVD) && (active_cfg.startup_time_select != SUT_RSVD);
   endproperty
   a_no_rsvd_src: assert property (p_no_rsvd_src) else $error("reserved code used");

   property p_flash_core;
      @(posedge mclk) disable iff (!rstn)
      clk_gate.core |-> clk_gate.flash && clk_gate.conv && !core_reset;
   endproperty
   a_flash_core: assert property (p_flash_core) else $error("gate mismatch");

   property p_div_spacing;
      @(posedge mclk) disable iff (!rstn)
      sys_clk_tick && (active_cfg.div8_n == FUSE_PROG) |=> !sys_clk_tick [*2];
   endproperty
   a_div_spacing: assert property (p_div_spacing) else $error("divide too fast");

   property p_tout_entry;
      @(posedge mclk) disable iff (!rstn)
      (cur_r.st == ST_HOLD) && sync_lvl[IN_RSTN] && (tout_cycles(fuse_lvl) != '0)
      |=> (cur_r.st == ST_TOUT) && core_reset;
   endproperty
   a_tout_entry: assert property (p_tout_entry) else $error("time-out skipped");

   property p_osc_entry;
      @(posedge mclk) disable iff (!rstn)
      (cur_r.st == ST_TOUT) && sync_rise[IN_WDT] && sync_lvl[IN_RSTN]
      && (cur_r.cnt == tout_cycles(cur_r.cfg) - 14'h1)
      |=> (cur_r.st == ST_OSC) && (cur_r.cnt == '0);
   endproperty
   a_osc_entry: assert property (p_osc_entry) else $error("time-out length wrong");

   property p_tout_reset;
      @(posedge mclk) disable iff (!rstn)
      ((cur_r.st == ST_TOUT) || (cur_r.st == ST_OSC)) |-> core_reset;
   endproperty
   a_tout_reset: assert property (p_tout_reset) else $error("reset dropped early");

   property p_wake_release;
      @(posedge mclk) disable iff (!rstn)
      (cur_r.st == ST_WAKE) && src_tick && sync_lvl[IN_RSTN]
      && (cur_r.cnt == OSC_WAKE_CYC - 14'h1)
      |=> (cur_r.st == ST_RUN) && clk_gate.core && !core_reset;
   endproperty
   a_wake_release: assert property (p_wake_release) else $error("wake count wrong");

   property p_pdown_quiet;
      @(posedge mclk) disable iff (!rstn)
      (cur_r.st == ST_PDOWN)
      |=> !sys_clk_tick && !fast_two_wire_tick && (clk_gate == 4'h0);
   endproperty
   a_pdown_quiet: assert property (p_pdown_quiet) else $error("clock in power-down");

   property p_sleep_gates;
      @(posedge mclk) disable iff (!rstn)
      (cur_r.st == ST_SLEEP) |-> clk_gate.conv && !clk_gate.core && !clk_gate.flash;
   endproperty
   a_sleep_gates: assert property (p_sleep_gates) else $error("sleep gates wrong");

   property p_fast_tick;
      @(posedge mclk) disable iff (!rstn)
      src_tick && (cur_r.st != ST_PDOWN) |=> fast_two_wire_tick;
   endproperty
   a_fast_tick: assert property (p_fast_tick) else $error("fast tick lost");

   property p_always_on;
      @(posedge mclk) disable iff (!rstn)
      1'b1 |=> wdt_osc_enable && async_detect_enable;
   endproperty
   a_always_on: assert property (p_always_on) else $error("enable dropped");

endmodule

//--- tb/osc_fuse_model.sv
/*
 Oscillator sources and fuse bank facing the clock start-up controller.
 Assumes the bench sets the fuses and calls pulse; sources stand still between bursts.
*/
`timescale 1ns/100ps
module osc_fuse_model
   import clk_startup_pkg::*;
(
   output logic [3:0] osc,
   output fuse_cfg_t  fuses
);
   // =====================================================================
   // Shipped fuses: longest time-out, no brown-out guard assumed
   initial
   begin
      osc   = 4'h0;
      fuses = CFG_DEFAULT;
   end

   // =====================================================================
   // Bursts of cycles; 160 ns period keeps edges on falling mclk edges
   task automatic pulse(input int which, input int n);
      repeat (n)
      begin
         osc[which] = 1'b1;
         #80;
         osc[which] = 1'b0;
         #80;
      end
   endtask

   task automatic set_fuses(input fuse_cfg_t f);
      fuses = f;
   endtask
endmodule

//--- tb/tb.sv
/*
 Self-checking bench for the clock start-up controller.
 Assumes osc_fuse_model as the oscillator and fuse side; time-outs shortened to 4 and 8.
*/
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         bad_count++; \
         $display("BAD %s expected %h seen %h", nm, exp, got); \
      end \
   end
module tb;
   import clk_startup_pkg::*;
   localparam int unsigned TS = 4;
   localparam int unsigned TL = 8;
   logic       mclk = 1'b0;
   logic       rstn = 1'b0;
   logic       other_rst_n = 1'b0;
   logic       wake_pin = 1'b0;
   logic [7:0] factory_trim = 8'h00;
   logic       trim_wr = 1'b0;
   logic [7:0] trim_wdata = 8'h00;
   logic       sleep_req = 1'b0;
   logic [1:0] sleep_mode = 2'h0;
   logic [3:0] osc;
   fuse_cfg_t  fuses;
   logic       core_reset, sys_tick, fast_tick, wdt_en, async_en;
   clk_gate_t  clk_gate;
   logic [7:0] trim_reg;
   fuse_cfg_t  active_cfg;
   int         bad_count = 0;
   int         samples_checked = 0;
   int         sys_cnt = 0;
   int         fast_cnt = 0;

   always #10 mclk = ~mclk;
   always @(posedge mclk)
   begin
      if (sys_tick === 1'b1) sys_cnt++;
      if (fast_tick === 1'b1) fast_cnt++;
   end

   osc_fuse_model i_osc_fuse_model (.osc(osc), .fuses(fuses));
   clk_startup_ctrl #(.TOUT_SHORT(TS), .TOUT_LONG(TL)) i_clk_startup_ctrl (
      .mclk(mclk), .rstn(rstn), .wdt_osc_pin(osc[IN_WDT]), .ext_clk_pin(osc[IN_EXT]),
      .rc_osc_pin(osc[IN_RC]), .lf_osc_pin(osc[IN_LF]), .other_reset_n_pin(other_rst_n),
      .wake_pin(wake_pin), .fuse_pins(fuses), .factory_trim(factory_trim),
      .trim_wr(trim_wr), .trim_wdata(trim_wdata), .sleep_req(sleep_req),
      .sleep_mode(sleep_mode), .core_reset(core_reset), .sys_clk_tick(sys_tick),
      .fast_two_wire_tick(fast_tick), .clk_gate(clk_gate),
      .oscillator_trim_register(trim_reg), .wdt_osc_enable(wdt_en),
      .async_detect_enable(async_en), .active_cfg(active_cfg));

   // =====================================================================
   // Shared tasks
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic conclude();
      if (bad_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Osc bursts during the time-out must not shorten the stabilising count
   task automatic startup(input fuse_cfg_t f, input int nw, input int sel,
                          input logic [7:0] trim);
      fuse_cfg_t exp_cfg;
      cyc(1);
      i_osc_fuse_model.set_fuses(f);
      factory_trim = trim;
      other_rst_n = 1'b0;
      cyc(8);
      `CHK("core_reset hold", 1'b1, core_reset)
      `CHK("trim load", trim, trim_reg)
      other_rst_n = 1'b1;
      cyc(4);
      if (nw > 0)
      begin
         i_osc_fuse_model.pulse(IN_WDT, nw - 1);
         i_osc_fuse_model.pulse(sel, 20);
         cyc(4);
         `CHK("core_reset tout", 1'b1, core_reset)
         i_osc_fuse_model.pulse(IN_WDT, 1);
      end
      i_osc_fuse_model.pulse(sel, 13);
      cyc(4);
      `CHK("core_reset osc", 1'b1, core_reset)
      i_osc_fuse_model.pulse(sel, 1);
      cyc(4);
      `CHK("core_reset run", 1'b0, core_reset)
      `CHK("gates run", 4'hf, clk_gate)
      exp_cfg = f;
      if (f.src == SRC_RSVD)
         exp_cfg.src = SRC_RC;
      if (f.startup_time_select == SUT_RSVD)
         exp_cfg.startup_time_select = SUT_LONG;
      `CHK("active cfg", exp_cfg, active_cfg)
   endtask

   task automatic ticks(input int sel, input int exp_sys);
      cyc(1);
      sys_cnt = 0;
      fast_cnt = 0;
      i_osc_fuse_model.pulse(sel, 16);
      cyc(4);
      `CHK("sys ticks", exp_sys, sys_cnt)
      `CHK("fast ticks", 16, fast_cnt)
   endtask

   task automatic sleep_test(input int sel);
      logic [3:0] exp_g [4];
      exp_g = '{4'h5, 4'h1, 4'h0, 4'h0};
      for (int m = 0; m < 4; m++)
      begin
         sleep_mode = m[1:0];
         sleep_req = 1'b1;
         cyc(1);
         sleep_req = 1'b0;
         cyc(1);
         `CHK("sleep gates", exp_g[m], clk_gate)
         wake_pin = 1'b1;
         cyc(5);
         if (m >= 2)
         begin
            `CHK("async detect", 1'b1, async_en)
            i_osc_fuse_model.pulse(sel, 5);
            cyc(4);
            `CHK("wake early", 4'h0, clk_gate)
            `CHK("no reset on wake", 1'b0, core_reset)
            i_osc_fuse_model.pulse(sel, 1);
            cyc(4);
         end
         `CHK("wake gates", 4'hf, clk_gate)
         wake_pin = 1'b0;
         cyc(4);
      end
   endtask

   // Power-on: reset held 16 cycles, then the always-on enables
   task automatic power_on();
      cyc(16);
      rstn = 1'b1;
      cyc(3);
      `CHK("wdt osc enable", 1'b1, wdt_en)
      `CHK("async enable", 1'b1, async_en)
   endtask

   // Run-time trim write, then fuse pins moved while running
   task automatic trim_and_freeze(input fuse_cfg_t keep, input fuse_cfg_t moved);
      trim_wdata = 8'hc3;
      trim_wr = 1'b1;
      cyc(1);
      trim_wr = 1'b0;
      cyc(1);
      `CHK("trim write", 8'hc3, trim_reg)
      i_osc_fuse_model.set_fuses(moved);
      cyc(4);
      `CHK("cfg frozen", keep, active_cfg)
   endtask

   // =====================================================================
   // Main sequence
   initial
   begin
      power_on();
      startup(CFG_DEFAULT, TL, IN_RC, 8'h5a);
      ticks(IN_RC, 2);
      trim_and_freeze(CFG_DEFAULT, '{SRC_EXT, SUT_NONE, FUSE_UNPRG, FUSE_UNPRG});
      sleep_test(IN_RC);
      startup('{SRC_EXT, SUT_NONE, FUSE_UNPRG, FUSE_UNPRG}, 0, IN_EXT, 8'h11);
      ticks(IN_EXT, 16);
      startup('{SRC_EXT, SUT_NONE, FUSE_UNPRG, FUSE_PROG}, TS, IN_EXT, 8'h22);
      startup('{SRC_LF, SUT_SHORT, FUSE_UNPRG, FUSE_UNPRG}, TS, IN_LF, 8'h33);
      sleep_test(IN_LF);
      startup('{SRC_RSVD, SUT_RSVD, FUSE_UNPRG, FUSE_UNPRG}, TL, IN_RC, 8'h44);
      conclude();
   end

   // Far above the few thousand cycles the sequence needs
   initial
   begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      conclude();
   end
endmodule
